// *** tfd_pkg.sv ***
// Purpose: Shared constants for the data-link and spare-code register block
// Assumes: 8-bit parallel register port, one 25 MHz clock
// Notes:   Offsets are the byte addresses of the register port
package tfd_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] SPARE_LEN_OFS  = 8'hBD;
  localparam logic [7:0] SPARE_ONE_OFS  = 8'hBE;
  localparam logic [7:0] SPARE_TWO_OFS  = 8'hBF;
  localparam logic [7:0] RX_LINK_OFS    = 8'hC0;
  localparam logic [7:0] TX_LINK_OFS    = 8'hC1;
  localparam logic [7:0] MATCH_ONE_OFS  = 8'hC2;
  localparam logic [7:0] MATCH_TWO_OFS  = 8'hC3;
  localparam logic [7:0] IB_CTRL_OFS    = 8'hC5;
  // ==========================================================================
  // Reset values and field layout
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] IB_WRITE_MASK  = 8'h6F;
  localparam logic [2:0] SPARE_LONG_SEL = 3'h7;
  localparam logic [4:0] SPARE_LONG_LEN = 5'h10;
  localparam logic [1:0] IB_SIZE_FOUR   = 2'h1;
  // ==========================================================================
  // Counts
  localparam logic [7:0] SPARE_INTEG    = 8'h30;
  localparam int         FIFO_DEPTH     = 8;
  localparam int         LINK_WIDTH     = 8;
endpackage : tfd_pkg

// *** tfd_fifo_if.sv ***
// Purpose: Valid/ready carrier between the block and its receive FIFO
// Assumes: Single clock domain
// Notes:   Width is a parameter
`timescale 1ns/1ps
interface tfd_fifo_if #(parameter int W = 8);
  logic [W-1:0] inData;
  logic         inValid;
  logic         inReady;
  logic [W-1:0] outData;
  logic         outValid;
  logic         outReady;
  modport fifo (input inData, inValid, outReady, output inReady, outData, outValid);
  modport user (output inData, inValid, outReady, input inReady, outData, outValid);
endinterface : tfd_fifo_if

// *** tfd_fifo.sv ***
// Purpose: Receive byte FIFO between serial capture and host register
// Assumes: Synchronous active-high reset
// Notes:   Full and empty are exact; push while full is refused via inReady
`timescale 1ns/1ps
module tfd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  tfd_fifo_if.fifo  q
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]   count_q, count_d;
  logic          push, pop;

  // ==========================================================================
  // Handshakes
  // Compare at the counter's full width; D itself does not fit in AW bits
  assign q.inReady  = (count_q != (AW+1)'(D));
  assign q.outValid = (count_q != '0);
  assign q.outData  = mem[rdPtr_q];
  assign push       = q.inValid && q.inReady;
  assign pop        = q.outValid && q.outReady;

  // Pointer and fill next values
  always_comb begin
    wrPtr_d = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= q.inData;
    end
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end
endmodule : tfd_fifo

// *** tfd_link_regs.sv ***
// Purpose: Spare-code, data-link and interleave-bus control registers
// Assumes: Line bit strobes and host port are synchronous to clk
// Notes:   Received bytes queue in an 8-deep FIFO ahead of the host register
`timescale 1ns/1ps
module tfd_link_regs
  import tfd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData_q,
  input  wire logic       codeSelect,
  input  wire logic [5:0] bocCode,
  input  wire logic       rxBitEn,
  input  wire logic       rxBit,
  input  wire logic       txBitEn,
  output logic            txBit_q,
  output logic            matchHit_q,
  output logic            overrun_q,
  output logic            spareDet_q,
  output logic      [1:0] ibSize_q,
  output logic            ibFourDev_q,
  output logic            ibEnable_q,
  output logic      [2:0] ibPosition_q
);
  // ==========================================================================
  // Declarations
  logic [2:0]  spareLen_q, spareLen_d;
  logic [7:0]  spareOne_q, spareOne_d, spareTwo_q, spareTwo_d;
  logic [7:0]  txByte_q, txByte_d, matchOne_q, matchOne_d, matchTwo_q, matchTwo_d;
  logic [7:0]  ibCtl_q, ibCtl_d, rdData_d;
  logic [7:0]  rxShift_q, rxShift_d, rxHold_q, rxHold_d, rxByte;
  logic [2:0]  rxCnt_q, rxCnt_d, txCnt_q, txCnt_d;
  logic [7:0]  txShift_q, txShift_d;
  logic        rxFull_q, rxFull_d, matchHit_d, overrun_d, txBit_d;
  logic        byteDone, readPop, take, defWrite;
  logic [15:0] hist_q, hist_d, cmpMask, cmpPat;
  logic [7:0]  integ_q, integ_d;
  logic        phaseOk_q, phaseOk_d, spareDet_d, windowHit, periodic;
  logic [4:0]  spareLen;
  logic [3:0]  lenM1;

  tfd_fifo_if #(.W(LINK_WIDTH)) rxq ();

  tfd_fifo #(.W(LINK_WIDTH), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk (clk),
    .rst (rst),
    .q   (rxq)
  );

  // ==========================================================================
  // Host port and receive path
  assign rxByte       = {rxBit, rxShift_q[7:1]};
  assign byteDone     = rxBitEn && (rxCnt_q == 3'h7);
  assign readPop      = rdEn && (addr == RX_LINK_OFS) && !codeSelect;
  assign rxq.inData   = rxByte;
  assign rxq.inValid  = byteDone;
  assign rxq.outReady = !rxFull_q || readPop;
  assign take         = rxq.outValid && rxq.outReady;
  assign defWrite     = wrEn && (addr == SPARE_LEN_OFS || addr == SPARE_ONE_OFS
                                 || addr == SPARE_TWO_OFS);

  // Register writes, read mux and receive capture next values
  always_comb begin
    spareLen_d = spareLen_q;
    spareOne_d = spareOne_q;
    spareTwo_d = spareTwo_q;
    txByte_d   = txByte_q;
    matchOne_d = matchOne_q;
    matchTwo_d = matchTwo_q;
    ibCtl_d    = ibCtl_q;
    if (wrEn) begin
      unique case (addr)
        SPARE_LEN_OFS: spareLen_d = wrData[2:0];
        SPARE_ONE_OFS: spareOne_d = wrData;
        SPARE_TWO_OFS: spareTwo_d = wrData;
        TX_LINK_OFS:   txByte_d   = wrData;
        MATCH_ONE_OFS: matchOne_d = wrData;
        MATCH_TWO_OFS: matchTwo_d = wrData;
        IB_CTRL_OFS:   ibCtl_d    = wrData & IB_WRITE_MASK;
        default:       ;
      endcase
    end
    rdData_d = rdData_q;
    if (rdEn) begin
      unique case (addr)
        SPARE_LEN_OFS: rdData_d = {5'h00, spareLen_q};
        SPARE_ONE_OFS: rdData_d = spareOne_q;
        SPARE_TWO_OFS: rdData_d = spareTwo_q;
        // Mode bit picks bit-oriented code or queued byte
        RX_LINK_OFS:   rdData_d = codeSelect ? {2'h0, bocCode} : rxHold_q;
        TX_LINK_OFS:   rdData_d = txByte_q;
        MATCH_ONE_OFS: rdData_d = matchOne_q;
        MATCH_TWO_OFS: rdData_d = matchTwo_q;
        IB_CTRL_OFS:   rdData_d = ibCtl_q;
        default:       rdData_d = REG_RESET;
      endcase
    end
    rxShift_d  = rxBitEn ? rxByte : rxShift_q;
    rxCnt_d    = rxBitEn ? 3'(rxCnt_q + 3'h1) : rxCnt_q;
    rxHold_d   = take ? rxq.outData : rxHold_q;
    rxFull_d   = take || (rxFull_q && !readPop);
    matchHit_d = byteDone && (rxByte == matchOne_q || rxByte == matchTwo_q);
    // Serial line cannot stall, so a full queue loses the byte
    overrun_d  = overrun_q || (byteDone && !rxq.inReady);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      spareLen_q <= 3'h0;
      spareOne_q <= REG_RESET;
      spareTwo_q <= REG_RESET;
      txByte_q   <= REG_RESET;
      matchOne_q <= REG_RESET;
      matchTwo_q <= REG_RESET;
      ibCtl_q    <= REG_RESET;
      rdData_q   <= REG_RESET;
      rxShift_q  <= REG_RESET;
      rxCnt_q    <= 3'h0;
      rxHold_q   <= REG_RESET;
      rxFull_q   <= 1'b0;
      matchHit_q <= 1'b0;
      overrun_q  <= 1'b0;
      ibSize_q   <= 2'h0;
      ibFourDev_q  <= 1'b0;
      ibEnable_q   <= 1'b0;
      ibPosition_q <= 3'h0;
    end else begin
      spareLen_q <= spareLen_d;
      spareOne_q <= spareOne_d;
      spareTwo_q <= spareTwo_d;
      txByte_q   <= txByte_d;
      matchOne_q <= matchOne_d;
      matchTwo_q <= matchTwo_d;
      ibCtl_q    <= ibCtl_d;
      rdData_q   <= rdData_d;
      rxShift_q  <= rxShift_d;
      rxCnt_q    <= rxCnt_d;
      rxHold_q   <= rxHold_d;
      rxFull_q   <= rxFull_d;
      matchHit_q <= matchHit_d;
      overrun_q  <= overrun_d;
      ibSize_q   <= ibCtl_d[6:5];
      ibFourDev_q  <= (ibCtl_d[6:5] == IB_SIZE_FOUR);
      ibEnable_q   <= ibCtl_d[3];
      ibPosition_q <= ibCtl_d[2:0];
    end
  end

  // ==========================================================================
  // Transmit serializer, sends bit 0 of the byte first
  always_comb begin
    txShift_d = txShift_q;
    txCnt_d   = txCnt_q;
    txBit_d   = txBit_q;
    if (txBitEn) begin
      txCnt_d = 3'(txCnt_q + 3'h1);
      if (txCnt_q == 3'h0) begin
        txBit_d   = txByte_q[0];
        txShift_d = {1'b0, txByte_q[7:1]};
      end else begin
        txBit_d   = txShift_q[0];
        txShift_d = {1'b0, txShift_q[7:1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txShift_q <= REG_RESET;
      txCnt_q   <= 3'h0;
      txBit_q   <= 1'b0;
    end else begin
      txShift_q <= txShift_d;
      txCnt_q   <= txCnt_d;
      txBit_q   <= txBit_d;
    end
  end

  // ==========================================================================
  // Spare-code repeat detector on the receive bit stream
  assign spareLen  = (spareLen_q == SPARE_LONG_SEL) ? SPARE_LONG_LEN
                                                    : {2'h0, spareLen_q} + 5'h1;
  assign lenM1     = 4'(spareLen - 5'h1);
  assign cmpMask   = 16'((17'h1 << spareLen) - 17'h1);
  // Only the top L pattern bits survive, so code two drops out below 8/16
  assign cmpPat    = 16'({spareOne_q, spareTwo_q} >> (5'h10 - spareLen));
  assign windowHit = (((hist_d ^ cmpPat) & cmpMask) == 16'h0000);
  assign periodic  = (rxBit == hist_q[lenM1]);

  always_comb begin
    hist_d     = rxBitEn ? {hist_q[14:0], rxBit} : hist_q;
    phaseOk_d  = phaseOk_q;
    integ_d    = integ_q;
    spareDet_d = spareDet_q;
    if (defWrite) begin
      phaseOk_d  = 1'b0;
      integ_d    = 8'h00;
      spareDet_d = 1'b0;
    end else if (rxBitEn) begin
      if (!periodic) begin
        phaseOk_d = windowHit;
        integ_d   = 8'h00;
        spareDet_d = 1'b0;
      end else if (phaseOk_q || windowHit) begin
        phaseOk_d = 1'b1;
        if (integ_q != SPARE_INTEG) begin
          integ_d = 8'(integ_q + 8'h01);
        end
        spareDet_d = (integ_d == SPARE_INTEG);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_q     <= 16'h0000;
      phaseOk_q  <= 1'b0;
      integ_q    <= 8'h00;
      spareDet_q <= 1'b0;
    end else begin
      hist_q     <= hist_d;
      phaseOk_q  <= phaseOk_d;
      integ_q    <= integ_d;
      spareDet_q <= spareDet_d;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_rx_msb_last: assert property (byteDone |-> rxq.inData[7] == rxBit)
    else $error("last received bit not in bit 7");
  chk_boc_view: assert property (rdEn && addr == RX_LINK_OFS && codeSelect
    |=> rdData_q == {2'h0, $past(bocCode)})
    else $error("bit-oriented code view wrong");
  chk_fdl_view: assert property (rdEn && addr == RX_LINK_OFS && !codeSelect
    |=> rdData_q == $past(rxHold_q))
    else $error("received byte view wrong");
  chk_tx_first_bit: assert property (txBitEn && txCnt_q == 3'h0
    |=> txBit_q == $past(txByte_q[0]))
    else $error("transmit byte not sent bit 0 first");
  chk_tx_last_bit: assert property (txBitEn && txCnt_q == 3'h7
    |=> txBit_q == $past(txShift_q[0]))
    else $error("transmit byte not ended with its last bit");
  chk_match_flag: assert property (byteDone && (rxByte == matchTwo_q) |=> matchHit_q)
    else $error("match code missed");
  chk_def_restart: assert property (defWrite |=> integ_q == 8'h00 && !spareDet_q)
    else $error("definition write did not restart integration");
  chk_short_len: assert property (spareLen_q == 3'h6
    |-> cmpMask == 16'h007F && cmpPat[6:0] == spareOne_q[7:1])
    else $error("seven-bit length compares wrong bits");
  chk_one_bit_len: assert property (spareLen_q == 3'h0 |-> cmpPat[0] == spareOne_q[7])
    else $error("one-bit length not taken from bit 7");
  chk_bus_four: assert property (wrEn && addr == IB_CTRL_OFS && wrData[6:5] == 2'h1
    |=> ibFourDev_q && ibCtl_q[7] == 1'b0 && ibCtl_q[4] == 1'b0)
    else $error("four-device bus size not decoded");

  cov_byte_queued: cover property (byteDone && rxq.inReady);
  cov_match_seen:  cover property (matchHit_q);
  cov_spare_found: cover property (spareDet_q);
  cov_overrun:     cover property ($rose(overrun_q));
endmodule : tfd_link_regs

// *** tfd_line_model.sv ***
// Purpose: Line-side partner that feeds received bits and takes sent bits
// Assumes: Strobes change at the falling edge of clk
// Notes:   A released receive line shows the inverse of its last bit
`timescale 1ns/1ps
module tfd_line_model (
  input  wire logic clk,
  output logic      rxBitEn,
  output logic      rxBit,
  output logic      txBitEn,
  input  wire logic txBit
);
  // ==========================================================================
  // Idle state
  initial begin
    rxBitEn = 1'b0;
    rxBit   = 1'b0;
    txBitEn = 1'b0;
  end

  // ==========================================================================
  // Receive side
  // Bit 0 goes first; fast keeps strobes back to back, slow leaves gaps
  task automatic send_bits(input logic [7:0] v, input int n, input bit fast);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rxBitEn = 1'b1;
      rxBit   = v[i];
      if (!fast) begin
        @(negedge clk);
        rxBitEn = 1'b0;
        rxBit   = ~v[i];
      end
    end
    @(negedge clk);
    rxBitEn = 1'b0;
    rxBit   = ~v[n-1]; // Stale data must not pass for a new bit
  endtask : send_bits

  // ==========================================================================
  // Transmit side
  // One strobe per bit; the answer is taken a full cycle later
  task automatic take_bit(output logic b);
    @(negedge clk);
    txBitEn = 1'b1;
    @(negedge clk);
    txBitEn = 1'b0;
    b       = txBit;
  endtask : take_bit
endmodule : tfd_line_model

// *** test_tfd_link_regs.sv ***
// Purpose: Self-checking bench for the link register block
// Assumes: Host port and line strobes change at the falling edge
// Notes:   Line side is played by tfd_line_model
`timescale 1ns/1ps
module test_tfd_link_regs
  import tfd_pkg::*;
();
  logic       clk = 1'b0;
  logic       rst, wrEn, rdEn, codeSelect, rxBitEn, rxBit, txBitEn, txBit;
  logic       matchHit, overrun, spareDet, ibFourDev, ibEnable;
  logic [7:0] addr, wrData, rdData;
  logic [5:0] bocCode;
  logic [1:0] ibSize;
  logic [2:0] ibPosition;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         hitCnt = 0;

  // ==========================================================================
  // Clock, design and partner
  always #20 clk = ~clk;

  tfd_link_regs u_tfd_link_regs (
    .clk(clk), .rst(rst), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
    .wrData(wrData), .rdData_q(rdData), .codeSelect(codeSelect),
    .bocCode(bocCode), .rxBitEn(rxBitEn), .rxBit(rxBit), .txBitEn(txBitEn),
    .txBit_q(txBit), .matchHit_q(matchHit), .overrun_q(overrun),
    .spareDet_q(spareDet), .ibSize_q(ibSize), .ibFourDev_q(ibFourDev),
    .ibEnable_q(ibEnable), .ibPosition_q(ibPosition)
  );

  tfd_line_model u_tfd_line_model (
    .clk(clk), .rxBitEn(rxBitEn), .rxBit(rxBit), .txBitEn(txBitEn), .txBit(txBit)
  );

  // Match pulses are one cycle wide, so count them as they pass
  always @(posedge clk) begin
    if (matchHit === 1'b1) hitCnt <= hitCnt + 1;
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr   = a;
    wrData = d;
    wrEn   = 1'b1;
    @(negedge clk);
    wrEn   = 1'b0;
  endtask : reg_wr

  // Read data lands on the edge between the two falling edges
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rdEn = 1'b1;
    @(negedge clk);
    rdEn = 1'b0;
    chk(rdData, exp);
  endtask : rd_chk

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] adr [10] = '{8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC5,
                             8'hC4, 8'h00};
    foreach (adr[i]) rd_chk(adr[i], REG_RESET);
    chk({1'b0, ibSize, ibFourDev, ibEnable, ibPosition}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] adr [5] = '{8'hBE, 8'hBF, 8'hC1, 8'hC2, 8'hC3};
    foreach (adr[i]) reg_wr(adr[i], 8'hA0 + 8'(i));
    foreach (adr[i]) rd_chk(adr[i], 8'hA0 + 8'(i));
    reg_wr(8'hC0, 8'h77);
    rd_chk(8'hC0, 8'h00);
    reg_wr(8'hC4, 8'h55);
    rd_chk(8'hC4, 8'h00);
    reg_wr(IB_CTRL_OFS, 8'hFF); // Reserved bits set on purpose
    rd_chk(IB_CTRL_OFS, 8'h6F);
    chk({1'b0, ibSize, ibFourDev, ibEnable, ibPosition}, 8'h6F);
    for (int p = 0; p < 4; p++) begin
      reg_wr(IB_CTRL_OFS, 8'h28 | 8'(p));
      chk({1'b0, ibSize, ibFourDev, ibEnable, ibPosition}, 8'h38 | 8'(p));
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_boc;
    logic [5:0] code [3] = '{6'h3F, 6'h2A, 6'h15};
    codeSelect = 1'b1;
    foreach (code[i]) begin
      bocCode = code[i];
      rd_chk(RX_LINK_OFS, {2'b00, code[i]});
    end
    codeSelect = 1'b0;
    $display("test bit code done");
  endtask : t_boc

  task automatic t_rx_match;
    logic [7:0] b [3] = '{8'hA5, 8'h3C, 8'h5A};
    int         h;
    reg_wr(MATCH_ONE_OFS, 8'hA5);
    reg_wr(MATCH_TWO_OFS, 8'h3C);
    foreach (b[i]) begin
      h = hitCnt;
      u_tfd_line_model.send_bits(b[i], 8, (i % 2) == 1);
      repeat (2) @(negedge clk);
      chk(8'(hitCnt - h), (i < 2) ? 8'h01 : 8'h00);
      rd_chk(RX_LINK_OFS, b[i]);
    end
    $display("test receive match done");
  endtask : t_rx_match

  // Nine bytes fit (queue plus holder); the tenth is lost
  task automatic t_fifo;
    for (int i = 0; i < 10; i++) begin
      if (i == 9) chk({7'h0, overrun}, 8'h00);
      u_tfd_line_model.send_bits(8'h10 + 8'(i), 8, 1'b1);
    end
    repeat (2) @(negedge clk);
    chk({7'h0, overrun}, 8'h01);
    for (int i = 0; i < 9; i++) rd_chk(RX_LINK_OFS, 8'h10 + 8'(i));
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_tx;
    logic [7:0] v;
    logic       b;
    reg_wr(TX_LINK_OFS, 8'h96);
    for (int i = 0; i < 16; i++) begin
      if (i == 4) reg_wr(TX_LINK_OFS, 8'h3C); // Mid-byte write waits for next byte
      u_tfd_line_model.take_bit(b);
      v[i % 8] = b;
      if (i == 7) chk(v, 8'h96);
    end
    chk(v, 8'h3C);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_spare;
    reg_wr(SPARE_LEN_OFS, 8'h02);
    reg_wr(SPARE_ONE_OFS, 8'hBF);
    reg_wr(SPARE_TWO_OFS, 8'h5A);
    repeat (50) u_tfd_line_model.send_bits(8'h01, 3, 1'b1);
    chk({7'h0, spareDet}, 8'h00);
    repeat (50) u_tfd_line_model.send_bits(8'h05, 3, 1'b1);
    chk({7'h0, spareDet}, 8'h01);
    reg_wr(SPARE_TWO_OFS, 8'h00);
    @(negedge clk);
    chk({7'h0, spareDet}, 8'h00);
    reg_wr(SPARE_LEN_OFS, 8'h07);
    reg_wr(SPARE_ONE_OFS, 8'hF0);
    reg_wr(SPARE_TWO_OFS, 8'h0F);
    repeat (8) begin
      u_tfd_line_model.send_bits(8'h0F, 8, 1'b1);
      u_tfd_line_model.send_bits(8'hF0, 8, 1'b1);
    end
    chk({7'h0, spareDet}, 8'h01);
    reg_wr(SPARE_LEN_OFS, 8'h06); // Seven-bit code, second byte left nonzero
    reg_wr(SPARE_ONE_OFS, 8'hA9);
    repeat (20) u_tfd_line_model.send_bits(8'h15, 7, 1'b1);
    chk({7'h0, spareDet}, 8'h01);
    $display("test spare code done");
  endtask : t_spare

  // ==========================================================================
  // Verdict and run control
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Whole run needs about a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst        = 1'b1;
    wrEn       = 1'b0;
    rdEn       = 1'b0;
    addr       = 8'h00;
    wrData     = 8'h00;
    codeSelect = 1'b0;
    bocCode    = 6'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_boc();
    t_rx_match();
    t_fifo();
    t_tx();
    t_spare();
    end_of_test();
  end
endmodule : test_tfd_link_regs
